// ==== inc/sas_pkg.sv ====
// Purpose: shared types of the sweep sequencer
// Assumes: field layout matches sas_regs.svh
// Notes: none
package sas_pkg;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        sas_clk_div4,
        sas_clk_div2,
        sas_clk_div1,
        sas_clk_rsvd
    } sas_clk_sel_t;

    typedef struct packed {
        logic vref_on;
        logic [1:0] grp;
        logic alt;
        sas_clk_sel_t clk_sel;
        logic res8;
        logic start;
    } sas_ctrl_t;

    typedef enum logic {
        sas_idle,
        sas_convert
    } sas_state_t;

    typedef struct packed {
        logic [9:0] code;
        logic [2:0] chan;
        logic alt;
        logic vref_on;
    } sas_analog_t;
endpackage : sas_pkg

// ==== inc/sas_regs.svh ====
// Purpose: register map, field positions, reset values, timing counts
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH
// ****************************************************************
// offsets
// ****************************************************************
`define SAS_OFF_CTRL 8'h00
`define SAS_OFF_STAT 8'h04
`define SAS_OFF_RES0 8'h08
`define SAS_OFF_LAST 8'h24
// ****************************************************************
// control fields
// ****************************************************************
`define SAS_CTRL_START 0
`define SAS_CTRL_RES8 1
`define SAS_CTRL_CLK_LO 2
`define SAS_CTRL_CLK_HI 3
`define SAS_CTRL_ALT 4
`define SAS_CTRL_GRP_LO 5
`define SAS_CTRL_GRP_HI 6
`define SAS_CTRL_VREF 7
`define SAS_CTRL_RESET 8'h00
`define SAS_CTRL_MASK 8'hff
// ****************************************************************
// converter constants
// ****************************************************************
`define SAS_SAR_IDLE 10'h200
`define SAS_TOP_BIT 4'h9
`define SAS_STOP_10 4'h0
`define SAS_STOP_8 4'h2
`define SAS_LAST_CHAN 3'h7
`define SAS_DIV4_TERM 2'h3
`define SAS_DIV2_TERM 2'h1
`define SAS_DIV1_TERM 2'h0
`endif

// ==== testbench/sas_comparator_model.sv ====
// Purpose: comparator and reference ladder at the far side
// Assumes: ideal ladder, no settling delay
// Notes: levels in lsb units, alternate pins at index 8 to 12
`timescale 1ns/1ps
module sas_comparator_model (
    input wire sas_pkg::sas_analog_t analog,
    input wire logic [15:0][9:0] levels,
    output logic ref_below_input
);
    logic [3:0] idx;
    // pins are only read, never driven
    assign idx = {analog.alt && analog.chan < 3'h5, analog.chan};
    // step n sits half an lsb below n, so n <= vin is below
    assign ref_below_input = analog.code <= levels[idx];
endmodule : sas_comparator_model

// ==== testbench/sas_sequencer_sva.sv ====
// Purpose: port checker of the sweep sequencer
// Assumes: control word at offset zero, pready high
// Notes: control is shadowed from apb writes
`timescale 1ns/1ps
module sas_sequencer_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire sas_pkg::sas_analog_t analog
);
    logic [7:0] ctrl_q;
    logic [9:0] prev;
    logic [9:0] lsb;
    logic wr;
    logic run;
    assign wr = psel && penable && pready && pwrite && paddr == 8'h00;
    assign run = ctrl_q[0];
    assign lsb = prev & (~prev + 10'h001);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= 8'h00;
        else if (wr)
            ctrl_q <= pwdata[7:0];
    end
    always_ff @(posedge pclk)
    begin
        prev <= analog.code;
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_start_kick: assert property (
        wr && pwdata[0] && !run |-> ##[1:10]
        (analog.code != 10'h200 && analog.chan == 3'h0))
        else $error("start did not begin channel zero");
    chk_sweep_wrap: assert property (
        run && $past(run) && $changed(analog.chan)
        && $past(analog.chan) > {1'b0, ctrl_q[6:5]} |-> analog.chan == 3'h0)
        else $error("no return to channel zero");
    chk_no_irq: assert property (
        psel && penable && !pwrite && paddr == 8'h04 |-> !prdata[4])
        else $error("interrupt bit set");
    chk_div4_pace: assert property (
        run && ctrl_q[3:2] == 2'h0 && $changed(analog.code)
        |=> ($stable(analog.code) || !run)[*3])
        else $error("step faster than four clocks");
    chk_alt_route: assert property (
        analog.chan < 3'h5 |-> analog.alt == $past(ctrl_q[4]))
        else $error("alternate group not routed");
    chk_trial_bit: assert property (
        run && $past(run) && analog.code != prev && analog.code != 10'h200
        |-> analog.code == (prev | lsb >> 1)
        || analog.code == ((prev & ~lsb) | lsb >> 1))
        else $error("bad approximation step");
    chk_eight_bit: assert property (
        ctrl_q[1] |-> analog.code[1:0] == 2'h0)
        else $error("low bits tried in eight bit mode");
    chk_stop_idle: assert property (
        wr && !pwdata[0] && run |-> ##[1:3] (analog.code == 10'h200)[*4])
        else $error("stop left code off idle");
    cover property (run && ctrl_q[1]);
    cover property (run && ctrl_q[4]);
    cover property (run && ctrl_q[6:5] == 2'h3);
endmodule : sas_sequencer_sva
bind sas_sequencer sas_sequencer_sva chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .analog);

// ==== testbench/tb_sas_sequencer.sv ====
// Purpose: self checking bench of the sweep sequencer
// Assumes: zero wait apb, ideal comparator model
// Notes: rows sweep clock, width, group and pin choices
`timescale 1ns/1ps
`include "sas_regs.svh"
module tb_sas_sequencer;
    typedef struct {
        logic [7:0] cfg;
        logic [9:0] slope;
    } sas_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_below_input;
    sas_pkg::sas_analog_t analog;
    logic [15:0][9:0] levels = '0;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    sas_row_t rows [4] = '{'{8'h80, 10'h3ff}, '{8'hb6, 10'h155},
        '{8'hc8, 10'h000}, '{8'hfe, 10'h2ab}};
    sas_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ref_below_input, .analog);
    sas_comparator_model cmp (.analog, .levels, .ref_below_input);
    always #12.5 pclk = ~pclk;
    // ******
    // helpers
    // ******
    function automatic logic [9:0] lv(input logic [9:0] s, input int i);
        lv = (i > 7) ? ~(s * 10'(i - 7)) : s * 10'(i + 1);
    endfunction : lv
    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    // ******
    // sequence
    // ******
    initial
    begin
        logic [9:0] v;
        int per;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[r])
        begin
            for (int i = 0; i < 16; i++)
                levels[i] <= lv(rows[r].slope, i);
            apb(1'b1, 8'h00, {24'h0, rows[r].cfg & 8'h9e});
            apb(1'b1, 8'h00, {24'h0, rows[r].cfg});
            repeat (40) @(posedge pclk);
            chk("vref_on", {31'h0, rows[r].cfg[7]}, {31'h0, analog.vref_on});
            chk("alt_pins", {31'h0, rows[r].cfg[4]}, {31'h0, analog.alt});
            apb(1'b1, 8'h00, {24'h0, rows[r].cfg | 8'h01});
            apb(1'b0, `SAS_OFF_STAT, 32'h0);
            chk("busy_irq", 32'h1, rd & 32'h11);
            per = rows[r].cfg[3:2] == 2'h0 ? 4
                : rows[r].cfg[3:2] == 2'h1 ? 2 : 1;
            per = per * (rows[r].cfg[1] ? 8 : 10);
            repeat (24 * per) @(posedge pclk);
            apb(1'b1, 8'h00, {24'h0, rows[r].cfg});
            for (int i = 0; i < 8; i++)
            begin
                v = lv(rows[r].slope, (rows[r].cfg[4] && i < 5) ? i + 8 : i);
                apb(1'b0, 8'(8 + 4 * i), 32'h0);
                chk("result", rows[r].cfg[1] ? {24'h0, v[9:2]}
                    : {22'h0, v}, rd);
            end
        end
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, `SAS_OFF_STAT, 32'h1);
        chk("ro_write", 32'h1, {31'h0, er});
        apb(1'b1, 8'h00, 32'h81);
        repeat (7) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h80);
        repeat (3) @(posedge pclk);
        chk("idle_code", 32'h200, {22'h0, analog.code});
        apb(1'b1, 8'h00, 32'h81);
        repeat (9) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        chk("vref_reset", 32'h0, {31'h0, analog.vref_on});
        apb(1'b0, `SAS_OFF_RES0, 32'h0);
        chk("result_reset", 32'h0, rd);
        test_done();
    end
endmodule : tb_sas_sequencer

// ==== verilog/sas_sequencer.sv ====
// Purpose: repeat sweep mode 1 sequencer with ten-step approximation, eight steps in eight-bit mode
// Assumes: apb slave, zero wait states, comparator synchronous to pclk
// Notes: one converter, eight channels, no interrupt logic
//
// Function
// - start flag set begins channel zero
// - first result lands in result zero
// - selected sweep, one unselected, then restart
// - each result goes to its channel register
// - interrupt request bit never set here
// - converts continuously until start flag cleared
// - conversion clock divided four, two or one
// - alternate group reroutes first five channels
// - trigger loads top bit, then decides it
// - lower bits tried, kept if reference below
// - ten-bit result moved after bit zero
// - reference driven from approximation register
// - eight-bit mode keeps top eight bits
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sas_regs.svh"

module sas_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_below_input,
    output sas_pkg::sas_analog_t analog
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [2:0] last_sel(input logic [1:0] grp);
        last_sel = {1'b0, grp};
    endfunction : last_sel

    function automatic logic [2:0] first_unsel(input logic [1:0] grp);
        first_unsel = {1'b0, grp} + 3'h1;
    endfunction : first_unsel

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[1:0] == 2'h0) && (addr <= `SAS_OFF_LAST);
    endfunction : mapped

    // ************************************************************
    // state
    // ************************************************************
    sas_pkg::sas_ctrl_t ctrl;
    sas_pkg::sas_state_t state;
    logic [9:0] sar;
    logic [3:0] bitpos;
    logic [2:0] chan;
    logic [2:0] unsel;
    logic [1:0] div_cnt;
    logic [9:0] result [8];
    logic setup;
    logic wr_access;
    logic ctrl_wr;
    logic start_req;
    logic stop_req;
    logic tick;
    logic [1:0] div_term;
    logic [3:0] stop_bit;
    logic [9:0] next_sar;
    logic [9:0] next_result;
    logic chan_done;
    logic [2:0] next_chan;
    logic [2:0] next_unsel;
    logic [2:0] res_idx;
    logic [31:0] next_rdata;
    logic [9:0] next_code;
    logic [2:0] next_sel_chan;

    assign setup = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign ctrl_wr = wr_access && (paddr == `SAS_OFF_CTRL);
    assign start_req = ctrl_wr && pwdata[`SAS_CTRL_START]
                       && !ctrl.start;
    assign stop_req = ctrl_wr && !pwdata[`SAS_CTRL_START];

    // ************************************************************
    // control register
    // ************************************************************
    // every bit stays writable; keeping writes to a stopped converter
    // is left to software, the hardware does not lock them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= sas_pkg::sas_ctrl_t'(`SAS_CTRL_RESET);
        end
        else if (ctrl_wr)
        begin
            ctrl <= sas_pkg::sas_ctrl_t'(pwdata[7:0] & `SAS_CTRL_MASK);
        end
    end

    // ************************************************************
    // conversion clock
    // ************************************************************
    always_comb
    begin
        case (ctrl.clk_sel)
            sas_pkg::sas_clk_div4: div_term = `SAS_DIV4_TERM;
            sas_pkg::sas_clk_div2: div_term = `SAS_DIV2_TERM;
            default: div_term = `SAS_DIV1_TERM;
        endcase
    end

    // divider restarts with each start so the first step is not short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 2'h0;
        end
        else if (start_req || state == sas_pkg::sas_idle || tick)
        begin
            div_cnt <= 2'h0;
        end
        else
        begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    assign tick = (state == sas_pkg::sas_convert) && (div_cnt == div_term);

    // ************************************************************
    // approximation step
    // ************************************************************
    assign stop_bit = ctrl.res8 ? `SAS_STOP_8 : `SAS_STOP_10;
    assign chan_done = tick && (bitpos == stop_bit);

    always_comb
    begin
        next_sar = sar;
        next_sar[bitpos] = ref_below_input;
        if (bitpos != 4'h0)
        begin
            next_sar[bitpos - 4'h1] = 1'b1;
        end
        if (ctrl.res8)
        begin
            next_result = {2'h0, next_sar[9:2]};
        end
        else
        begin
            next_result = next_sar;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sar <= `SAS_SAR_IDLE;
            bitpos <= `SAS_TOP_BIT;
        end
        else if (stop_req || start_req || chan_done)
        begin
            sar <= `SAS_SAR_IDLE;
            bitpos <= `SAS_TOP_BIT;
        end
        else if (tick)
        begin
            sar <= next_sar;
            bitpos <= bitpos - 4'h1;
        end
    end

    // ************************************************************
    // channel sequence
    // ************************************************************
    always_comb
    begin
        next_unsel = unsel;
        if (chan < last_sel(ctrl.grp))
        begin
            next_chan = chan + 3'h1;
        end
        else if (chan == last_sel(ctrl.grp))
        begin
            // a four-channel group still has four unselected ones
            next_chan = unsel;
        end
        else
        begin
            next_chan = 3'h0;
            if (unsel == `SAS_LAST_CHAN)
            begin
                next_unsel = first_unsel(ctrl.grp);
            end
            else
            begin
                next_unsel = unsel + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= sas_pkg::sas_idle;
            chan <= 3'h0;
            unsel <= 3'h1;
        end
        else if (stop_req)
        begin
            state <= sas_pkg::sas_idle;
        end
        else if (start_req)
        begin
            state <= sas_pkg::sas_convert;
            chan <= 3'h0;
            unsel <= first_unsel(pwdata[`SAS_CTRL_GRP_HI:`SAS_CTRL_GRP_LO]);
        end
        else
        begin
            case (state)
                sas_pkg::sas_convert:
                begin
                    if (chan_done)
                    begin
                        chan <= next_chan;
                        unsel <= next_unsel;
                    end
                end
                default:
                begin
                    chan <= chan;
                end
            endcase
        end
    end

    // ************************************************************
    // result registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
            begin
                result[i] <= 10'h000;
            end
        end
        else if (chan_done)
        begin
            result[chan] <= next_result;
        end
    end

    // ************************************************************
    // analog side
    // ************************************************************
    // ladder shows the coming register value: at divide-by-one the
    // comparator is read again at the very next edge
    assign next_code = (stop_req || start_req || chan_done) ? `SAS_SAR_IDLE
                       : tick ? next_sar : sar;
    assign next_sel_chan = start_req ? 3'h0
                           : (chan_done && !stop_req) ? next_chan : chan;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog <= '0;
        end
        else
        begin
            analog.code <= next_code;
            analog.chan <= next_sel_chan;
            analog.alt <= ctrl.alt;
            analog.vref_on <= ctrl.vref_on;
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    assign res_idx = 3'(paddr[7:2] - 6'h2);

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (paddr == `SAS_OFF_CTRL)
        begin
            next_rdata[7:0] = ctrl;
        end
        else if (paddr == `SAS_OFF_STAT)
        begin
            // bit 4 is the interrupt request, held low in this mode
            next_rdata[0] = (state == sas_pkg::sas_convert);
            next_rdata[3:1] = chan;
            next_rdata[4] = 1'b0;
        end
        else if (mapped(paddr))
        begin
            next_rdata[9:0] = result[res_idx];
        end
    end

    // read data and error are prepared in the setup cycle, so
    // every access completes without wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b1;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !mapped(paddr)
                       || (pwrite && paddr != `SAS_OFF_CTRL);
            pready <= 1'b1;
        end
    end

endmodule : sas_sequencer
